// *** rtl/watchdog_clock_timer.sv ***
`include "wdt_clock_timer_map.svh"

// Behaviour
// - Oscillator rate bit 0 gives 400 kHz, 1 gives 25 kHz.
// - Without crystal select, oscillator select picks oscillator (1) or peripheral clock (0).
// - Crystal select 1 picks crystal oscillator, ignoring the other select bits.
// - New clock selection reaches the multiplexer only when a feed completes.
// - Switch drops old clock after two old cycles, picks new after two new.
// - Prescaler restarts at feed; switch error up to two old plus two new.
// - If old core clock stops mid-switch, oscillator is never selected; watchdog idle.
// - Control writes reach the shadow copy after one watchdog clock cycle.
// - Underflow sets timeout flag; interrupt only with watchdog enable bit set.
// - Software writing 0 clears the timeout flag.
// - Underflow reloads the down counter and counting continues.
// - Correct feed loads reload value; wrong feeds are ignored.
// - In power-down only the selected oscillator or crystal keeps running.
// - Peripheral clock source in power-down stops oscillator; watchdog disabled.
// - Underflow wakes the device from power-down.
// - Wake-up clears the oscillator rate bit, back to 400 kHz.
// - Counting runs while run control is 1 and stops while 0.
// - Timeout flag sets when the 8-bit down counter underflows.
// - Prescaler tap select divides by 32 times two to its power.
// - Both fuses set force run control and oscillator select to 1.
module watchdog_clock_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic pclkIn,
  input wire logic wdOscIn,
  input wire logic xtalIn,
  input wire logic watchdogEnableFuse,
  input wire logic safetyEnableFuse,
  input wire logic powerDown,
  output logic wdOscRun,
  output logic wdOscSlow,
  output logic xtalRun,
  output logic irq,
  output logic wakeUp,
  output logic wdDisabled
);

  localparam int NumSrc = 3;

  logic [NumSrc-1:0] srcSync1_q;
  logic [NumSrc-1:0] srcSync2_q;
  logic [NumSrc-1:0] srcPrev_q;
  logic [NumSrc-1:0] srcTick;
  logic [1:0] fuseSync1_q;
  logic [1:0] fuseSync2_q;
  logic fusesForce;
  logic access;
  logic wrStb;
  logic ack_q;
  logic [31:0] dat_q;
  wdt_clock_timer_pkg::ctrl_type ctrl_q;
  wdt_clock_timer_pkg::ctrl_type ctrlEff;
  wdt_clock_timer_pkg::ctrl_type shadow_q;
  logic flag_q;
  logic [7:0] reload_q;
  logic xtalSel_q;
  logic rate_q;
  logic ienWd_q;
  logic feedStage_q;
  logic feedDone;
  wdt_clock_timer_pkg::src_type reqSrc;
  wdt_clock_timer_pkg::src_type activeSrc_q;
  wdt_clock_timer_pkg::src_type pendSrc_q;
  wdt_clock_timer_pkg::switch_type sw_q;
  logic [1:0] swCnt_q;
  logic oldTick;
  logic newTick;
  logic selTick;
  logic [11:0] preCnt_q;
  logic [11:0] preLimit;
  logic preWrap;
  logic [7:0] count_q;
  logic underflow;
  logic wake_q;

  // Pin inputs pass two flops; a third flop only feeds the edge detect
  generate
    for (genvar i = 0; i < NumSrc; i++) begin : g_src
      always_ff @(posedge clk) begin
        if (rst) begin
          srcSync1_q[i] <= 1'b0;
          srcSync2_q[i] <= 1'b0;
          srcPrev_q[i] <= 1'b0;
        end else begin
          srcSync1_q[i] <= (i == 0) ? pclkIn : ((i == 1) ? wdOscIn : xtalIn);
          srcSync2_q[i] <= srcSync1_q[i];
          srcPrev_q[i] <= srcSync2_q[i];
        end
      end
      assign srcTick[i] = srcSync2_q[i] & ~srcPrev_q[i];
    end
  endgenerate

  // Fuse straps are pins too
  always_ff @(posedge clk) begin
    if (rst) begin
      fuseSync1_q <= 2'h0;
      fuseSync2_q <= 2'h0;
    end else begin
      fuseSync1_q <= {safetyEnableFuse, watchdogEnableFuse};
      fuseSync2_q <= fuseSync1_q;
    end
  end

  assign fusesForce = &fuseSync2_q;

  // Fuses override what software holds without losing its value
  always_comb begin
    ctrlEff = ctrl_q;
    if (fusesForce) begin
      ctrlEff.run = 1'b1;
      ctrlEff.oscSel = 1'b1;
    end
  end

  // Wishbone: ack one cycle after the request, writes land on the ack edge
  assign access = cyc_i & stb_i;
  assign wrStb = access & we_i & ack_q & sel_i[0];
  assign ack_o = ack_q;
  assign dat_o = dat_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access & ~ack_q;
    end
  end

  // Read data is captured as ack rises; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      dat_q <= 32'h0000_0000;
    end else if (access & ~ack_q & ~we_i) begin
      unique case (adr_i)
        `WDT_CTRL_OFS: dat_q <= {24'h000000, ctrlEff.prescale, 2'h0, ctrlEff.run, flag_q, ctrlEff.oscSel};
        `WDT_RELOAD_OFS: dat_q <= {24'h000000, reload_q};
        `WDT_CLKCFG_OFS: dat_q <= {26'h0000000, rate_q, xtalSel_q, 4'h0};
        `WDT_INTERRUPT_ENABLE_REG_0_OFS: dat_q <= {25'h0000000, ienWd_q, 6'h00};
        `WDT_STATUS_OFS: dat_q <= {16'h0000, count_q, 3'h0, sw_q, activeSrc_q};
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Software control fields
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= '{prescale: `WDT_PRE_RST, run: 1'b0, oscSel: 1'b0};
      reload_q <= `WDT_RELOAD_RST;
      xtalSel_q <= 1'b0;
      ienWd_q <= 1'b0;
    end else if (wrStb) begin
      if (adr_i == `WDT_CTRL_OFS) begin
        ctrl_q.prescale <= dat_i[`WDT_CTRL_PRE_MSB:`WDT_CTRL_PRE_LSB];
        ctrl_q.run <= dat_i[`WDT_CTRL_RUN_BIT];
        ctrl_q.oscSel <= dat_i[`WDT_CTRL_OSCSEL_BIT];
      end
      if (adr_i == `WDT_RELOAD_OFS) begin
        reload_q <= dat_i[7:0];
      end
      if (adr_i == `WDT_CLKCFG_OFS) begin
        xtalSel_q <= dat_i[`WDT_CLKCFG_XTAL_BIT];
      end
      if (adr_i == `WDT_INTERRUPT_ENABLE_REG_0_OFS) begin
        ienWd_q <= dat_i[`WDT_INTERRUPT_ENABLE_REG_0_WD_BIT];
      end
    end
  end

  // Rate bit: wake-up clearing beats a software write in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_q <= 1'b0;
    end else if (wake_q) begin
      rate_q <= 1'b0;
    end else if (wrStb && adr_i == `WDT_CLKCFG_OFS) begin
      rate_q <= dat_i[`WDT_CLKCFG_RATE_BIT];
    end
  end

  // Timeout flag: underflow wins over a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (underflow) begin
      flag_q <= 1'b1;
    end else if (wrStb && adr_i == `WDT_CTRL_OFS && !dat_i[`WDT_CTRL_FLAG_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  // Feed: first byte then second byte; anything else restarts the sequence
  assign feedDone = wrStb && adr_i == `WDT_FEED_OFS && feedStage_q && dat_i[7:0] == `WDT_FEED_SECOND;

  always_ff @(posedge clk) begin
    if (rst) begin
      feedStage_q <= 1'b0;
    end else if (wrStb && adr_i == `WDT_FEED_OFS) begin
      feedStage_q <= (dat_i[7:0] == `WDT_FEED_FIRST);
    end
  end

  // Requested source from the select bits
  always_comb begin
    if (xtalSel_q) begin
      reqSrc = wdt_clock_timer_pkg::SRC_XTAL;
    end else if (ctrlEff.oscSel) begin
      reqSrc = wdt_clock_timer_pkg::SRC_WDOSC;
    end else begin
      reqSrc = wdt_clock_timer_pkg::SRC_PCLK;
    end
  end

  assign oldTick = srcTick[activeSrc_q];
  assign newTick = srcTick[pendSrc_q];
  // Ticks pass only in the steady state, so no cut pulse reaches the prescaler
  assign selTick = (sw_q == wdt_clock_timer_pkg::SW_SEL) & oldTick;

  // Switch synchroniser; a stalled old clock leaves it waiting in the drop phase
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_q <= wdt_clock_timer_pkg::SW_SEL;
      swCnt_q <= 2'h0;
      activeSrc_q <= wdt_clock_timer_pkg::SRC_PCLK;
      pendSrc_q <= wdt_clock_timer_pkg::SRC_PCLK;
    end else begin
      unique case (sw_q)
        wdt_clock_timer_pkg::SW_SEL: begin
          if (feedDone && reqSrc != activeSrc_q) begin
            pendSrc_q <= reqSrc;
            sw_q <= wdt_clock_timer_pkg::SW_DROP;
            swCnt_q <= 2'h0;
          end
        end
        wdt_clock_timer_pkg::SW_DROP: begin
          if (oldTick) begin
            if (swCnt_q == `WDT_SWITCH_CYCLES - 2'h1) begin
              sw_q <= wdt_clock_timer_pkg::SW_PICK;
              swCnt_q <= 2'h0;
            end else begin
              swCnt_q <= swCnt_q + 2'h1;
            end
          end
        end
        wdt_clock_timer_pkg::SW_PICK: begin
          if (newTick) begin
            if (swCnt_q == `WDT_SWITCH_CYCLES - 2'h1) begin
              sw_q <= wdt_clock_timer_pkg::SW_SEL;
              activeSrc_q <= pendSrc_q;
              swCnt_q <= 2'h0;
            end else begin
              swCnt_q <= swCnt_q + 2'h1;
            end
          end
        end
        default: begin
          sw_q <= wdt_clock_timer_pkg::SW_SEL;
        end
      endcase
    end
  end

  // Shadow copy follows the control fields one watchdog clock later
  always_ff @(posedge clk) begin
    if (rst) begin
      shadow_q <= '{prescale: `WDT_PRE_RST, run: 1'b0, oscSel: 1'b0};
    end else if (selTick) begin
      shadow_q <= ctrlEff;
    end
  end

  // Divide by 32 << tap; tap 7 wraps to 4096 exactly
  assign preLimit = (`WDT_PRE_BASE << shadow_q.prescale) - 12'h001;
  assign preWrap = selTick && shadow_q.run && preCnt_q == preLimit;
  assign underflow = preWrap && count_q == 8'h00;

  // Prescaler restarts at a feed, so a switch after it costs some counts
  always_ff @(posedge clk) begin
    if (rst) begin
      preCnt_q <= 12'h000;
    end else if (feedDone) begin
      preCnt_q <= 12'h000;
    end else if (selTick && shadow_q.run) begin
      preCnt_q <= preWrap ? 12'h000 : preCnt_q + 12'h001;
    end
  end

  // Down counter: feed loads, underflow reloads and keeps going
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= `WDT_RELOAD_RST;
    end else if (feedDone) begin
      count_q <= reload_q;
    end else if (underflow) begin
      count_q <= reload_q;
    end else if (preWrap) begin
      count_q <= count_q - 8'h01;
    end
  end

  // Wake pulse on an underflow during power-down
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= underflow & powerDown;
    end
  end

  assign wakeUp = wake_q;
  assign irq = flag_q & ienWd_q;
  assign wdOscSlow = rate_q;
  // In power-down only the source actually in use keeps running
  assign wdOscRun = ~powerDown | (activeSrc_q == wdt_clock_timer_pkg::SRC_WDOSC);
  assign xtalRun = ~powerDown | (activeSrc_q == wdt_clock_timer_pkg::SRC_XTAL);
  assign wdDisabled = (sw_q != wdt_clock_timer_pkg::SW_SEL)
                    | (powerDown & activeSrc_q == wdt_clock_timer_pkg::SRC_PCLK);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence pickLast;
    sw_q == wdt_clock_timer_pkg::SW_PICK && newTick && swCnt_q == 2'h1;
  endsequence

  sequence dropLast;
    sw_q == wdt_clock_timer_pkg::SW_DROP && oldTick && swCnt_q == 2'h1;
  endsequence

  a_switch_pick: assert property (pickLast |=> sw_q == wdt_clock_timer_pkg::SW_SEL
    && activeSrc_q == $past(pendSrc_q)) else $error("switch did not complete after two new ticks");
  a_switch_drop: assert property (dropLast |=> sw_q == wdt_clock_timer_pkg::SW_PICK
    && activeSrc_q == $past(activeSrc_q)) else $error("old clock not dropped after two ticks");
  a_no_early_switch: assert property (!feedDone |=> $stable(pendSrc_q) || $past(sw_q) != wdt_clock_timer_pkg::SW_SEL)
    else $error("selection changed without a feed");
  a_tick_gated: assert property (sw_q != wdt_clock_timer_pkg::SW_SEL |=> $stable(preCnt_q) || $past(feedDone))
    else $error("prescaler moved during a switch");
  a_flag_set: assert property (underflow |=> flag_q) else $error("underflow did not set the flag");
  a_irq_level: assert property (flag_q && ienWd_q |-> irq) else $error("interrupt low with flag and enable");
  a_reload_under: assert property (underflow && !feedDone |=> count_q == $past(reload_q))
    else $error("counter not reloaded on underflow");
  a_feed_load: assert property (feedDone |=> count_q == $past(reload_q) && preCnt_q == 12'h000)
    else $error("feed did not load counter");
  a_run_stop: assert property (!shadow_q.run && !feedDone |=> $stable(count_q))
    else $error("counter moved while stopped");
  a_fuse_force: assert property (!$past(rst) && !$past(rst, 2) && $past(watchdogEnableFuse, 2)
    && $past(safetyEnableFuse, 2) |-> ctrlEff.run && ctrlEff.oscSel) else $error("fuses did not force run");
  a_wake_rate: assert property (underflow && powerDown |=> wakeUp ##1 !rate_q) else $error("no wake");
  a_stall_hold: assert property (sw_q == wdt_clock_timer_pkg::SW_DROP && !oldTick |=> $stable(sw_q))
    else $error("switch went on without an old tick");
  a_pd_pclk: assert property (powerDown && activeSrc_q == wdt_clock_timer_pkg::SRC_PCLK |-> !wdOscRun && wdDisabled)
    else $error("oscillator kept running with peripheral clock");

endmodule : watchdog_clock_timer

// *** rtl/wdt_clock_timer_map.svh ***
`ifndef WDT_CLOCK_TIMER_MAP_SVH
`define WDT_CLOCK_TIMER_MAP_SVH

// Byte offsets of the 32-bit register words
`define WDT_CTRL_OFS 8'h00
`define WDT_RELOAD_OFS 8'h04
`define WDT_FEED_OFS 8'h08
`define WDT_CLKCFG_OFS 8'h0C
`define WDT_INTERRUPT_ENABLE_REG_0_OFS 8'h10
`define WDT_STATUS_OFS 8'h14

// Control register fields
`define WDT_CTRL_OSCSEL_BIT 0
`define WDT_CTRL_FLAG_BIT 1
`define WDT_CTRL_RUN_BIT 2
`define WDT_CTRL_PRE_LSB 5
`define WDT_CTRL_PRE_MSB 7

// Clock configuration fields
`define WDT_CLKCFG_XTAL_BIT 4
`define WDT_CLKCFG_RATE_BIT 5

// Interrupt enable register 0 field
`define WDT_INTERRUPT_ENABLE_REG_0_WD_BIT 6

// Feed sequence bytes
`define WDT_FEED_FIRST 8'hA5
`define WDT_FEED_SECOND 8'h5A

// Reset values
`define WDT_RELOAD_RST 8'hFF
`define WDT_PRE_RST 3'h7

// Synchroniser depth on a switch, in source cycles
`define WDT_SWITCH_CYCLES 2'h2

// Prescaler base division
`define WDT_PRE_BASE 12'h020

// Oscillator rates, rate bit 0 and 1
`define WDT_OSC_FAST_KHZ 400
`define WDT_OSC_SLOW_KHZ 25

`endif

// *** rtl/wdt_clock_timer_pkg.sv ***
package wdt_clock_timer_pkg;

  // Watchdog clock sources, also the index of each source tick
  typedef enum logic [1:0] {
    SRC_PCLK = 2'h0,
    SRC_WDOSC = 2'h1,
    SRC_XTAL = 2'h2
  } src_type;

  // Clock switch synchroniser states
  typedef enum logic [2:0] {
    SW_SEL = 3'h1,
    SW_DROP = 3'h2,
    SW_PICK = 3'h4
  } switch_type;

  // Fields of the control register that steer counting
  typedef struct packed {
    logic [2:0] prescale;
    logic run;
    logic oscSel;
  } ctrl_type;

endpackage : wdt_clock_timer_pkg

// *** dv/watchdog_clock_timer_bench.sv ***
`include "wdt_clock_timer_map.svh"

module watchdog_clock_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} note_type;
  localparam logic [7:0] CTL = `WDT_CTRL_OFS;
  localparam logic [7:0] RLD = `WDT_RELOAD_OFS;
  localparam logic [7:0] FED = `WDT_FEED_OFS;
  localparam logic [7:0] CFG = `WDT_CLKCFG_OFS;
  localparam logic [7:0] IEN = `WDT_INTERRUPT_ENABLE_REG_0_OFS;
  localparam logic [7:0] STA = `WDT_STATUS_OFS;

  logic clk, rst, cyc_i, stb_i, we_i, ack_o, pclkIn, wdOscIn, xtalIn, wdFuse, safeFuse, powerDown;
  logic wdOscRun, wdOscSlow, xtalRun, irq, wakeUp, wdDisabled, pclkStop;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic [7:0] ctlTab [4] = '{8'h01, 8'h01, 8'h00, 8'h00};
  logic [7:0] cfgTab [4] = '{8'h30, 8'h20, 8'h10, 8'h00};
  int srcTab [4] = '{2, 1, 2, 0};
  int failures, num_checks, divCnt, r, tp, c, t, prevSrc;
  note_type notes[$];
  note_type n;

  watchdog_clock_timer dut_u (
    .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pclkIn(pclkIn), .wdOscIn(wdOscIn), .xtalIn(xtalIn),
    .watchdogEnableFuse(wdFuse), .safetyEnableFuse(safeFuse), .powerDown(powerDown),
    .wdOscRun(wdOscRun), .wdOscSlow(wdOscSlow), .xtalRun(xtalRun), .irq(irq), .wakeUp(wakeUp),
    .wdDisabled(wdDisabled)
  );

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Slow source pins with distinct periods, all far below a quarter of clk
  always @(posedge clk) begin
    divCnt <= divCnt + 1;
    pclkIn <= (divCnt % 8) < 4 && !pclkStop; // Stopping it mimics a halted core clock
    wdOscIn <= (divCnt % 10) < 5;
    xtalIn <= (divCnt % 12) < 6;
  end

  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask : check

  // Read data is matched against the oldest note when the ack shows
  always @(posedge clk) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && notes.size() > 0) begin
      n = notes.pop_front();
      check(n.name, n.exp & n.mask, dat_o & n.mask);
    end
  end

  // One classic cycle; the request is held until ack is sampled high
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int k;
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50) check("ack", 32'h1, 32'h0);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus

  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m, string nm);
    notes.push_back('{nm, e, m});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rd

  task automatic feed;
    wr(FED, {24'h0, `WDT_FEED_FIRST});
    wr(FED, {24'h0, `WDT_FEED_SECOND});
  endtask : feed

  task automatic idle(int k);
    repeat (k) @(posedge clk);
  endtask : idle

  // Bounded wait for irq or for the wake pulse
  task automatic await(bit useWake, int limit, output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((useWake ? wakeUp : irq) !== 1'b1 && k < limit);
    if (k >= limit) check("await", 32'h1, 32'h0);
  endtask : await

  task automatic close_out;
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Watchdog sized well above the longest timer periods used below
  initial begin
    #200000;
    failures++;
    close_out();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    wdFuse = 1'b0;
    safeFuse = 1'b0;
    powerDown = 1'b0;
    divCnt = 0;
    pclkStop = 1'b0;
    failures = 0;
    num_checks = 0;
    prevSrc = 0;
    t = $urandom(73683);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(CTL, 32'h000000E0, 32'h000000FF, "ctrl reset");
    rd(RLD, 32'h000000FF, 32'h000000FF, "reload reset");
    rd(STA, 32'h00000004, 32'h0000001F, "status reset");
    wr(8'h18, 32'h000000FF);
    rd(8'h18, 32'h0, 32'hFFFFFFFF, "unmapped");
    bus(1'b1, RLD, 32'h00000012, 4'hE);
    rd(RLD, 32'h000000FF, 32'h000000FF, "reload no lane");
    check("irq reset", 32'h0, 32'(irq));
    // Every source selection, switched only by a feed
    for (int i = 0; i < 4; i++) begin
      wr(CTL, {24'h0, ctlTab[i]});
      wr(CFG, {24'h0, cfgTab[i]});
      rd(STA, 32'h4 | prevSrc, 32'h0000001F, "source before feed");
      feed();
      idle(4);
      check("switching", 32'h1, 32'(wdDisabled));
      idle(150);
      rd(STA, 32'h4 | srcTab[i], 32'h0000001F, "source");
      check("osc slow", 32'(cfgTab[i][5]), 32'(wdOscSlow));
      powerDown <= 1'b1;
      idle(3);
      check("osc run", 32'(srcTab[i] == 1), 32'(wdOscRun));
      check("xtal run", 32'(srcTab[i] == 2), 32'(xtalRun));
      check("disabled", 32'(srcTab[i] == 0), 32'(wdDisabled));
      powerDown <= 1'b0;
      prevSrc = srcTab[i];
    end
    // Underflow period, flag, interrupt gating and reload with random settings
    r = $urandom % 4;
    tp = $urandom % 2;
    wr(RLD, 32'(r));
    wr(IEN, 32'h00000040);
    wr(CTL, 32'(tp << 5) | 32'h4);
    feed();
    await(1'b0, 5000, c);
    t = divCnt;
    rd(CTL, 32'h00000006, 32'h00000006, "flag set");
    wr(CTL, 32'(tp << 5) | 32'h4);
    idle(1);
    check("irq cleared", 32'h0, 32'(irq));
    await(1'b0, 5000, c);
    check("period", 32'((r + 1) * 256 << tp), 32'(divCnt - t));
    wr(IEN, 32'h0);
    idle(1);
    check("irq masked", 32'h0, 32'(irq));
    rd(CTL, 32'h00000002, 32'h00000002, "flag held");
    wr(CTL, 32'h0);
    wr(IEN, 32'h00000040);
    idle(3000);
    check("stopped", 32'h0, 32'(irq));
    // Correct feed reloads the counter, a broken one is ignored
    wr(RLD, 32'h000000FF);
    wr(CTL, 32'h00000004);
    feed();
    rd(STA, 32'h0000FF00, 32'h0000FF00, "count fed");
    idle(600);
    rd(STA, 32'h0000FD00, 32'h0000FF00, "count run");
    wr(FED, {24'h0, `WDT_FEED_FIRST});
    wr(FED, 32'h00000033);
    rd(STA, 32'h0000FD00, 32'h0000FF00, "bad feed");
    feed();
    rd(STA, 32'h0000FF00, 32'h0000FF00, "refed");
    // Wake from power-down on the slow oscillator clears the rate bit
    wr(CFG, 32'h00000020);
    wr(RLD, 32'h0);
    wr(CTL, 32'h00000005);
    feed();
    idle(100);
    check("slow set", 32'h1, 32'(wdOscSlow));
    powerDown <= 1'b1;
    await(1'b1, 2000, c);
    idle(2);
    check("rate cleared", 32'h0, 32'(wdOscSlow));
    powerDown <= 1'b0;
    // Old core clock halted right after the feed: the switch must wait in its drop phase
    wr(CTL, 32'h0);
    feed();
    idle(100);
    rd(STA, 32'h00000004, 32'h0000001F, "back on pclk");
    wr(CTL, 32'h00000001);
    feed();
    pclkStop <= 1'b1;
    idle(100);
    check("stalled", 32'h1, 32'(wdDisabled));
    rd(STA, 32'h00000008, 32'h0000001F, "stalled source");
    pclkStop <= 1'b0;
    idle(100);
    rd(STA, 32'h00000005, 32'h0000001F, "resumed source");
    // Both fuses hold run and oscillator select high
    wdFuse <= 1'b1;
    safeFuse <= 1'b1;
    idle(6);
    wr(CTL, 32'h0);
    rd(CTL, 32'h00000005, 32'h00000005, "forced");
    idle(4);
    close_out();
  end
endmodule : watchdog_clock_timer_bench
